//--- testbench/mdr_link_asserts.sv
`timescale 1ns/1ns
module mdr_link_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic [7:0] rsp_exc
);
  wire rd = req_valid && !req_write;
  wire wr = req_valid && req_write;
  wire mon = req_addr >= 16'h9d09 && req_addr <= 16'h9d48;
  wire cmd = req_addr >= 16'h9c42 && req_addr <= 16'h9c47;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  rsp_follows_a: assert property (req_valid |=> rsp_valid)
    else $error("no answer to request");
  no_stray_a: assert property (!req_valid |=> !rsp_valid)
    else $error("answer without request");
  mon_wr_refused_a: assert property (wr && mon |=> rsp_exc == 8'h02)
    else $error("monitor write accepted");
  cmd_rd_refused_a: assert property (
    rd && (cmd || req_addr == 16'h9c4f) |=>
    rsp_exc == 8'h02 && rsp_rdata == 16'h0000)
    else $error("write-only read accepted");
  reset_any_a: assert property (
    wr && req_addr == 16'h9c42 |=> rsp_exc == 8'h00)
    else $error("reset write refused");
  wrong_key_a: assert property (
    wr && req_addr == 16'h9c43 && req_wdata != 16'h965a |=>
    rsp_exc == 8'h00)
    else $error("wrong key not ignored");
  status_gaps_a: assert property (
    rd && req_addr == 16'h9c49 |=> (rsp_rdata & 16'h7d20) == 16'h0000)
    else $error("status gap bit set");
  mode_code_a: assert property (
    rd && req_addr == 16'h9c4a |=>
    rsp_rdata inside {16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0005})
    else $error("bad mode read code");
  absent_zero_a: assert property (
    rd && req_addr == 16'h9c48 |=> rsp_rdata == 16'h0000 ##0 rsp_exc == 8'h02)
    else $error("absent read not zero");
  freq_wr_ok_a: assert property (
    wr && req_addr == 16'h9c4e |=> rsp_exc == 8'h00 && rsp_rdata == 16'h0000)
    else $error("frequency write refused");
  mode_wr_legal_a: assert property (
    wr && req_addr == 16'h9c4a |->
    req_wdata == 16'h0010 || req_wdata == 16'h0014)
    else $error("illegal mode code sent");
  cover property (wr ##1 rsp_exc == 8'h00);
  cover property (rd ##1 rsp_exc == 8'h02);
  cover property (rd && req_addr == 16'h9c49);
endmodule // mdr_link_asserts

//--- testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import mdr_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  mdr_status_t drive_status = '0;
  mdr_inputs_t input_terminals = '0;
  mdr_mode_t mode_status = MDR_MODE_EXT;
  logic [MON_TOTAL-1:0][15:0] mon_values;
  logic [15:0] out_speed = 16'h0bb8;
  logic [15:0] set_speed = 16'h0640;
  logic [SPD_W-1:0] speed_display_setting = '0;
  logic cmd_valid = 1'b0, cmd_write = 1'b0, clr_go = 1'b0;
  logic [15:0] cmd_addr = '0, cmd_wdata = '0;
  mdr_clr_t clr_kind = MDR_CLR_PARAM;
  logic drive_reset_r, param_clear_r, all_clear_r, keep_comm_r;
  logic mode_wr_r, freq_nv_wr_r, cmd_ready_r, res_valid_r;
  logic [15:0] ctrl_word_r, freq_ram_r, freq_nv_data_r, res_rdata_r;
  logic [7:0] res_exc_r;
  mdr_mode_t mode_req_r;
  int mismatches = 0, checked = 0;
  int n_rst = 0, n_pc = 0, n_ac = 0, n_kc = 0, n_mw = 0, n_nv = 0;
  int n_pk = 0;
  logic [15:0] ka [4] = '{KEY_PCLR, KEY_ACLR, KEY_PCLR_KC, KEY_ACLR_KC};
  logic [15:0] aa [4] = '{A_PCLR, A_ACLR, A_PCLR_KC, A_ACLR_KC};
  logic [15:0] mc [5] = '{MODE_RD_EXT, MODE_RD_PANEL, MODE_RD_JOG,
    MODE_RD_NET, MODE_RD_PANEL_EXT};

  mdr_link_if link();
  mdr_device u_mdr_device (.clk(clk), .rst_b(rst_b), .link(link.dev),
    .drive_status(drive_status), .input_terminals(input_terminals),
    .mode_status(mode_status), .mon_values(mon_values),
    .out_speed(out_speed), .set_speed(set_speed),
    .speed_display_setting(speed_display_setting),
    .drive_reset_r(drive_reset_r), .param_clear_r(param_clear_r),
    .all_clear_r(all_clear_r), .keep_comm_r(keep_comm_r),
    .ctrl_word_r(ctrl_word_r), .mode_wr_r(mode_wr_r),
    .mode_req_r(mode_req_r), .freq_ram_r(freq_ram_r),
    .freq_nv_wr_r(freq_nv_wr_r), .freq_nv_data_r(freq_nv_data_r));
  mdr_master u_mdr_master (.clk(clk), .rst_b(rst_b), .link(link.mst),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .clr_go(clr_go), .clr_kind(clr_kind),
    .cmd_ready_r(cmd_ready_r), .res_valid_r(res_valid_r),
    .res_rdata_r(res_rdata_r), .res_exc_r(res_exc_r));
  mdr_link_asserts u_mdr_link_asserts (.clk(clk), .rst_b(rst_b),
    .req_valid(link.req_valid), .req_write(link.req_write),
    .req_addr(link.req_addr), .req_wdata(link.req_wdata),
    .rsp_valid(link.rsp_valid), .rsp_rdata(link.rsp_rdata),
    .rsp_exc(link.rsp_exc));

  initial begin
    forever #25 clk = ~clk;
  end

  // Pulses last one cycle, so they are tallied rather than sampled
  always @(posedge clk) begin
    n_rst <= n_rst + drive_reset_r;
    n_pc <= n_pc + param_clear_r;
    n_ac <= n_ac + all_clear_r;
    n_kc <= n_kc + keep_comm_r;
    n_mw <= n_mw + mode_wr_r;
    n_nv <= n_nv + freq_nv_wr_r;
    n_pk <= n_pk + (param_clear_r & keep_comm_r);
  end

  task test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task chkn(input int got, input int exp);
    chk(got[15:0], exp[15:0]);
  endtask

  // Request held until taken, then the result is awaited
  task go(input logic k, input logic w, input logic [15:0] a, d);
    int i;
    i = 0;
    if (k) begin
      clr_go <= 1'b1;
      clr_kind <= mdr_clr_t'(d[1:0]);
    end else begin
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_addr <= a;
      cmd_wdata <= d;
    end
    do begin
      @(posedge clk);
      i++;
    end while (cmd_ready_r !== 1'b1 && i < 20);
    cmd_valid <= 1'b0;
    clr_go <= 1'b0;
    do begin
      @(posedge clk);
      i++;
    end while (res_valid_r !== 1'b1 && i < 40);
    if (i >= 40)
      mismatches++;
  endtask

  task wr(input logic [15:0] a, d);
    go(1'b0, 1'b1, a, d);
  endtask

  task rd(input logic [15:0] a);
    go(1'b0, 1'b0, a, 16'h0000);
  endtask

  task exc(input logic [7:0] e);
    chk({8'h00, res_exc_r}, {8'h00, e});
  endtask

  task tend(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    for (int i = 0; i < MON_TOTAL; i++)
      mon_values[i] = 16'h1000 + 16'(i);
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk(ctrl_word_r, 16'h0000);
    chk(freq_ram_r, 16'h0000);
    chk(16'(mode_req_r), 16'(MDR_MODE_EXT));
    tend("reset");
    wr(A_DRIVE_RESET, 16'h1234);
    exc(EXC_NONE);
    chkn(n_rst, 1);
    rd(A_DRIVE_RESET);
    exc(EXC_ADDR);
    for (int i = 0; i < 4; i++) begin
      wr(aa[i], ka[i] ^ 16'h0001);
      exc(EXC_NONE);
    end
    chkn(n_pc + n_ac + n_kc, 0);
    for (int i = 0; i < 4; i++)
      wr(aa[i], ka[i]);
    chkn(n_pc, 2);
    chkn(n_ac, 2);
    chkn(n_kc, 2);
    chkn(n_pk, 1);
    go(1'b1, 1'b1, 16'h0000, 16'(MDR_CLR_ALL_KC));
    chkn(n_ac, 3);
    chkn(n_kc, 3);
    tend("clears");
    wr(A_CTRL, 16'hffff);
    chk(ctrl_word_r, 16'h05bf);
    drive_status <= '1;
    rd(A_CTRL);
    chk(res_rdata_r, 16'h82df);
    rd(16'h9d18);
    chk(res_rdata_r & 16'h00a1, 16'h00a1);
    drive_status <= '0;
    rd(A_CTRL);
    chk(res_rdata_r, 16'h0000);
    input_terminals <= 5'b00101;
    rd(16'h9d17);
    chk(res_rdata_r & 16'h003b, 16'h0009);
    tend("control");
    wr(A_MODE, MODE_WR_NET);
    chk(16'(mode_req_r), 16'(MDR_MODE_NET));
    wr(A_MODE, 16'h0003);
    exc(EXC_VALUE);
    wr(A_MODE, MODE_WR_EXT);
    chk(16'(mode_req_r), 16'(MDR_MODE_EXT));
    chkn(n_mw, 2);
    for (int m = 0; m < 5; m++) begin
      mode_status <= mdr_mode_t'(m);
      rd(A_MODE);
      chk(res_rdata_r, mc[m]);
    end
    tend("mode");
    wr(A_FREQ_RAM, 16'h1388);
    rd(A_FREQ_RAM);
    chk(res_rdata_r, 16'h1388);
    wr(A_FREQ_NV, 16'h0abc);
    chk(freq_nv_data_r, 16'h0abc);
    chk(freq_ram_r, 16'h1388);
    chkn(n_nv, 1);
    rd(A_FREQ_NV);
    exc(EXC_ADDR);
    tend("frequency");
    for (int i = 0; i < MON_N; i++)
      if (i != MON_IX_IN_TERM && i != MON_IX_OUT_TERM) begin
        rd(MON_ADDR[i]);
        chk(res_rdata_r, 16'h1000 + 16'(i));
      end
    rd(A_MON_THERMISTOR);
    chk(res_rdata_r, 16'h1016);
    rd(16'h9d11);
    chk(res_rdata_r, 16'h1005);
    wr(16'h9d0a, 16'h5555);
    exc(EXC_ADDR);
    rd(16'h9d0a);
    chk(res_rdata_r, 16'h1001);
    speed_display_setting <= SPD_MAX;
    rd(16'h9d09);
    chk(res_rdata_r, 16'h0bb8);
    rd(16'h9d0d);
    chk(res_rdata_r, 16'h0640);
    // Just past the top of the speed range falls back to frequency
    speed_display_setting <= 20'hf4179;
    rd(16'h9d09);
    chk(res_rdata_r, 16'h1000);
    tend("monitor");
    rd(16'h9c48);
    chk(res_rdata_r, 16'h0000);
    wr(16'h9c48, 16'h00ff);
    exc(EXC_ADDR);
    tend("absent");
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule // tb_top

//--- verilog/mdr_device.sv
`timescale 1ns/1ns
// Functional notes
// - Any write to reset register resets drive
// - Key 965a at 9c43 clears parameters
// - Key 99aa at 9c44 clears all
// - Key 5a96 at 9c46 clears parameters
// - Key aa99 at 9c47 clears all
// - Those two clears keep communication parameters
// - Control written, status read at 9c49
// - Control word bit layout, unused bits dropped
// - Status word bit layout, gaps read zero
// - Mode register: write selects, read reports
// - Mode codes; only 0010 and 0014 accepted
// - Running frequency RAM read/write, EEPROM write-only
// - Frequency monitors switch to speed by setting
// - Current and voltage monitors scaled
// - Duty and load monitors in 0.1 percent
// - Thermal, power, resistance monitors scaled
// - Input terminal monitor bit layout
// - Output terminal monitor bit layout
// - Unhandled address answers exception 02
// - Absent register reads zero, write discarded
module mdr_device (
  input wire logic clk,
  input wire logic rst_b,
  mdr_link_if.dev link,
  input wire mdr_pkg::mdr_status_t drive_status,
  input wire mdr_pkg::mdr_inputs_t input_terminals,
  input wire mdr_pkg::mdr_mode_t mode_status,
  input wire logic [mdr_pkg::MON_TOTAL-1:0][15:0] mon_values,
  input wire logic [15:0] out_speed,
  input wire logic [15:0] set_speed,
  input wire logic [mdr_pkg::SPD_W-1:0] speed_display_setting,
  output logic drive_reset_r,
  output logic param_clear_r,
  output logic all_clear_r,
  output logic keep_comm_r,
  output logic [15:0] ctrl_word_r,
  output logic mode_wr_r,
  output mdr_pkg::mdr_mode_t mode_req_r,
  output logic [15:0] freq_ram_r,
  output logic freq_nv_wr_r,
  output logic [15:0] freq_nv_data_r
);
  import mdr_pkg::*;

  logic rsp_valid_r;
  logic [15:0] rsp_rdata_r;
  logic [EXC_W-1:0] rsp_exc_r;

  // Linear search; the table is small and fixed
  function automatic logic [MON_IW:0] mon_lookup(input logic [15:0] a);
    logic [MON_IW:0] r;
    r = '0;
    for (int i = 0; i < MON_N; i++) begin
      if (a == MON_ADDR[i]) begin
        r = {1'b1, i[MON_IW-1:0]};
      end
    end
    if (a == A_MON_THERMISTOR) begin
      r = {1'b1, 5'h16};
    end
    return r;
  endfunction

  function automatic logic [15:0] mode_code(input mdr_mode_t m);
    logic [15:0] c;
    c = MODE_RD_EXT;
    case (m)
      MDR_MODE_PANEL: c = MODE_RD_PANEL;
      MDR_MODE_JOG: c = MODE_RD_JOG;
      MDR_MODE_NET: c = MODE_RD_NET;
      MDR_MODE_PANEL_EXT: c = MODE_RD_PANEL_EXT;
      default: c = MODE_RD_EXT;
    endcase
    return c;
  endfunction

  wire acc = link.req_valid;
  wire wr = acc & link.req_write;
  wire rd = acc & ~link.req_write;
  wire [15:0] addr = link.req_addr;
  wire [15:0] wdata = link.req_wdata;

  wire hit_reset = (addr == A_DRIVE_RESET);
  wire hit_pclr = (addr == A_PCLR);
  wire hit_aclr = (addr == A_ACLR);
  wire hit_pclr_kc = (addr == A_PCLR_KC);
  wire hit_aclr_kc = (addr == A_ACLR_KC);
  wire hit_ctrl = (addr == A_CTRL);
  wire hit_mode = (addr == A_MODE);
  wire hit_freq_ram = (addr == A_FREQ_RAM);
  wire hit_freq_nv = (addr == A_FREQ_NV);
  wire [MON_IW:0] mon_sel = mon_lookup(addr);
  wire hit_mon = mon_sel[MON_IW];
  wire [MON_IW-1:0] mon_ix = mon_sel[MON_IW-1:0];

  // Clear commands fire only on an exact key
  wire go_pclr = wr & hit_pclr & (wdata == KEY_PCLR);
  wire go_aclr = wr & hit_aclr & (wdata == KEY_ACLR);
  wire go_pclr_kc = wr & hit_pclr_kc & (wdata == KEY_PCLR_KC);
  wire go_aclr_kc = wr & hit_aclr_kc & (wdata == KEY_ACLR_KC);

  wire mode_wr_ext = (wdata == MODE_WR_EXT);
  wire mode_wr_net = (wdata == MODE_WR_NET);
  wire mode_ok = mode_wr_ext | mode_wr_net;
  wire go_mode = wr & hit_mode & mode_ok;

  wire clr_hit = hit_pclr | hit_aclr | hit_pclr_kc | hit_aclr_kc;
  // Monitors are deliberately absent from the writable set
  wire writable = hit_reset | clr_hit | hit_ctrl | hit_mode |
                  hit_freq_ram | hit_freq_nv;
  wire readable = hit_ctrl | hit_mode | hit_freq_ram | hit_mon;

  // Status word; bits not listed stay zero
  wire [15:0] status_word = {
    drive_status.fault_occurred, 5'h00,
    drive_status.safety_monitor, 1'b0,
    drive_status.fault_relay, drive_status.frequency_detected, 1'b0,
    drive_status.overload_flag, drive_status.up_to_frequency,
    drive_status.reverse, drive_status.forward,
    drive_status.running};

  // Undetermined terminal bits are driven as zero
  wire [15:0] in_term_word = {10'h000,
    input_terminals.high_speed_select,
    input_terminals.middle_speed_select,
    input_terminals.low_speed_select, 1'b0,
    input_terminals.reverse_start,
    input_terminals.forward_start};
  wire [15:0] out_term_word = {8'h00, drive_status.safety_monitor, 1'b0,
    drive_status.fault_relay, 4'h0, drive_status.running};

  // Speed display range switches frequency monitors to speed
  wire speed_mode = (speed_display_setting >= SPD_MIN) &&
                    (speed_display_setting <= SPD_MAX);

  // Monitor values arrive already in their register units
  wire [15:0] mon_raw = mon_values[mon_ix];
  wire is_out_freq = (mon_ix == MON_IX_OUT_FREQ[MON_IW-1:0]);
  wire is_set_freq = (mon_ix == MON_IX_SET_FREQ[MON_IW-1:0]);
  wire is_in_term = (mon_ix == MON_IX_IN_TERM[MON_IW-1:0]);
  wire is_out_term = (mon_ix == MON_IX_OUT_TERM[MON_IW-1:0]);
  wire [15:0] mon_word =
    (is_out_freq && speed_mode) ? out_speed :
    (is_set_freq && speed_mode) ? set_speed :
    is_in_term ? in_term_word :
    is_out_term ? out_term_word : mon_raw;

  wire [15:0] rd_word =
    hit_ctrl ? status_word :
    hit_mode ? mode_code(mode_status) :
    hit_freq_ram ? freq_ram_r :
    hit_mon ? mon_word : 16'h0000;

  wire [EXC_W-1:0] exc_nxt =
    (rd && !readable) ? EXC_ADDR :
    (wr && !writable) ? EXC_ADDR :
    (wr && hit_mode && !mode_ok) ? EXC_VALUE : EXC_NONE;

  wire [15:0] rdata_nxt = (rd && readable) ? rd_word : 16'h0000;

  assign link.rsp_valid = rsp_valid_r;
  assign link.rsp_rdata = rsp_rdata_r;
  assign link.rsp_exc = rsp_exc_r;

  // One answer per request, the cycle after it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= 16'h0000;
      rsp_exc_r <= EXC_NONE;
    end else begin
      rsp_valid_r <= acc;
      rsp_rdata_r <= rdata_nxt;
      rsp_exc_r <= acc ? exc_nxt : EXC_NONE;
    end
  end

  // Command pulses, one cycle each
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_reset_r <= 1'b0;
      param_clear_r <= 1'b0;
      all_clear_r <= 1'b0;
      keep_comm_r <= 1'b0;
    end else begin
      drive_reset_r <= wr & hit_reset;
      param_clear_r <= go_pclr | go_pclr_kc;
      all_clear_r <= go_aclr | go_aclr_kc;
      keep_comm_r <= go_pclr_kc | go_aclr_kc;
    end
  end

  // Control word holds only defined bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_word_r <= CTRL_RST;
    end else if (wr && hit_ctrl) begin
      ctrl_word_r <= wdata & CTRL_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_wr_r <= 1'b0;
      mode_req_r <= MDR_MODE_EXT;
    end else begin
      mode_wr_r <= go_mode;
      if (go_mode) begin
        mode_req_r <= mode_wr_net ? MDR_MODE_NET : MDR_MODE_EXT;
      end
    end
  end

  // EEPROM write leaves the RAM copy alone
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      freq_ram_r <= FREQ_RST;
      freq_nv_wr_r <= 1'b0;
      freq_nv_data_r <= FREQ_RST;
    end else begin
      freq_nv_wr_r <= wr & hit_freq_nv;
      if (wr && hit_freq_ram) begin
        freq_ram_r <= wdata;
      end
      if (wr && hit_freq_nv) begin
        freq_nv_data_r <= wdata;
      end
    end
  end
endmodule // mdr_device

//--- verilog/mdr_link_if.sv
`timescale 1ns/1ns
interface mdr_link_if;
  logic req_valid;
  logic req_write;
  logic [15:0] req_addr;
  logic [15:0] req_wdata;
  logic rsp_valid;
  logic [15:0] rsp_rdata;
  logic [7:0] rsp_exc;
  modport dev (
    input req_valid,
    input req_write,
    input req_addr,
    input req_wdata,
    output rsp_valid,
    output rsp_rdata,
    output rsp_exc
  );
  modport mst (
    output req_valid,
    output req_write,
    output req_addr,
    output req_wdata,
    input rsp_valid,
    input rsp_rdata,
    input rsp_exc
  );
endinterface

//--- verilog/mdr_master.sv
`timescale 1ns/1ns
module mdr_master (
  input wire logic clk,
  input wire logic rst_b,
  mdr_link_if.mst link,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  input wire logic clr_go,
  input wire mdr_pkg::mdr_clr_t clr_kind,
  output logic cmd_ready_r,
  output logic res_valid_r,
  output logic [15:0] res_rdata_r,
  output logic [7:0] res_exc_r
);
  import mdr_pkg::*;

  typedef enum logic {MDR_IDLE, MDR_WAIT} mdr_mst_state_t;

  mdr_mst_state_t state_r;
  logic req_valid_r;
  logic req_write_r;
  logic [15:0] req_addr_r;
  logic [15:0] req_wdata_r;

  // Each clear kind carries its own address and key
  function automatic logic [31:0] clr_frame(input mdr_clr_t k);
    logic [31:0] f;
    f = {A_PCLR, KEY_PCLR};
    case (k)
      MDR_CLR_ALL: f = {A_ACLR, KEY_ACLR};
      MDR_CLR_PARAM_KC: f = {A_PCLR_KC, KEY_PCLR_KC};
      MDR_CLR_ALL_KC: f = {A_ACLR_KC, KEY_ACLR_KC};
      default: f = {A_PCLR, KEY_PCLR};
    endcase
    return f;
  endfunction

  wire take_cmd = cmd_ready_r & cmd_valid;
  wire take_clr = cmd_ready_r & ~cmd_valid & clr_go;
  // Illegal mode writes never reach the link
  wire bad_mode = cmd_write & (cmd_addr == A_MODE) &
                  (cmd_wdata != MODE_WR_EXT) &
                  (cmd_wdata != MODE_WR_NET);
  wire [31:0] clr_f = clr_frame(clr_kind);
  wire issue = (take_cmd & ~bad_mode) | take_clr;

  assign link.req_valid = req_valid_r;
  assign link.req_write = req_write_r;
  assign link.req_addr = req_addr_r;
  assign link.req_wdata = req_wdata_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_valid_r <= 1'b0;
      req_write_r <= 1'b0;
      req_addr_r <= 16'h0000;
      req_wdata_r <= 16'h0000;
    end else begin
      req_valid_r <= issue;
      if (issue) begin
        req_write_r <= take_cmd ? cmd_write : 1'b1;
        req_addr_r <= take_cmd ? cmd_addr : clr_f[31:16];
        req_wdata_r <= take_cmd ? cmd_wdata : clr_f[15:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= MDR_IDLE;
      cmd_ready_r <= 1'b0;
      res_valid_r <= 1'b0;
      res_rdata_r <= 16'h0000;
      res_exc_r <= EXC_NONE;
    end else begin
      res_valid_r <= 1'b0;
      case (state_r)
        MDR_IDLE: begin
          cmd_ready_r <= ~issue;
          if (take_cmd && bad_mode) begin
            res_valid_r <= 1'b1;
            res_rdata_r <= 16'h0000;
            res_exc_r <= EXC_VALUE;
          end else if (issue) begin
            state_r <= MDR_WAIT;
          end
        end
        MDR_WAIT: begin
          if (link.rsp_valid) begin
            res_valid_r <= 1'b1;
            res_rdata_r <= link.rsp_rdata;
            res_exc_r <= link.rsp_exc;
            cmd_ready_r <= 1'b1;
            state_r <= MDR_IDLE;
          end
        end
        default: state_r <= MDR_IDLE;
      endcase
    end
  end
endmodule // mdr_master

//--- verilog/mdr_pkg.sv
package mdr_pkg;
  localparam int DW = 16;
  localparam int EXC_W = 8;

  // Holding-register addresses, as carried on the link
  localparam logic [15:0] A_DRIVE_RESET = 16'h9c42;
  localparam logic [15:0] A_PCLR = 16'h9c43;
  localparam logic [15:0] A_ACLR = 16'h9c44;
  localparam logic [15:0] A_PCLR_KC = 16'h9c46;
  localparam logic [15:0] A_ACLR_KC = 16'h9c47;
  localparam logic [15:0] A_CTRL = 16'h9c49;
  localparam logic [15:0] A_MODE = 16'h9c4a;
  localparam logic [15:0] A_FREQ_RAM = 16'h9c4e;
  localparam logic [15:0] A_FREQ_NV = 16'h9c4f;

  // Clear keys
  localparam logic [15:0] KEY_PCLR = 16'h965a;
  localparam logic [15:0] KEY_ACLR = 16'h99aa;
  localparam logic [15:0] KEY_PCLR_KC = 16'h5a96;
  localparam logic [15:0] KEY_ACLR_KC = 16'haa99;

  // Operation mode codes
  localparam logic [15:0] MODE_RD_EXT = 16'h0000;
  localparam logic [15:0] MODE_RD_PANEL = 16'h0001;
  localparam logic [15:0] MODE_RD_JOG = 16'h0002;
  localparam logic [15:0] MODE_RD_NET = 16'h0004;
  localparam logic [15:0] MODE_RD_PANEL_EXT = 16'h0005;
  localparam logic [15:0] MODE_WR_EXT = 16'h0010;
  localparam logic [15:0] MODE_WR_NET = 16'h0014;

  // Control word bits
  localparam int CB_STOP = 0;
  localparam int CB_FORWARD = 1;
  localparam int CB_REVERSE = 2;
  localparam int CB_HIGH = 3;
  localparam int CB_MIDDLE = 4;
  localparam int CB_LOW = 5;
  localparam int CB_SECOND_FN = 7;
  localparam int CB_TERM4 = 8;
  localparam int CB_OUTPUT_STOP = 10;
  localparam logic [15:0] CTRL_MASK = 16'h05bf;
  localparam logic [15:0] CTRL_RST = 16'h0000;

  // Status word bits
  localparam int SB_RUNNING = 0;
  localparam int SB_FORWARD = 1;
  localparam int SB_REVERSE = 2;
  localparam int SB_UP_TO_FREQ = 3;
  localparam int SB_OVERLOAD = 4;
  localparam int SB_FREQ_DET = 6;
  localparam int SB_FAULT_RELAY = 7;
  localparam int SB_SAFETY = 9;
  localparam int SB_FAULT = 15;

  // Terminal monitor bits
  localparam int IT_FORWARD = 0;
  localparam int IT_REVERSE = 1;
  localparam int IT_LOW = 3;
  localparam int IT_MIDDLE = 4;
  localparam int IT_HIGH = 5;
  localparam int OT_RUNNING = 0;
  localparam int OT_FAULT_RELAY = 5;
  localparam int OT_SAFETY = 7;

  localparam logic [15:0] FREQ_RST = 16'h0000;

  // Monitor table; index is the slot in the monitor input array
  localparam int MON_N = 22;
  localparam int MON_IW = 5;
  localparam logic [15:0] MON_ADDR [MON_N] = '{
    16'h9d09, 16'h9d0a, 16'h9d0b, 16'h9d0d, 16'h9d10, 16'h9d11,
    16'h9d12, 16'h9d13, 16'h9d14, 16'h9d16, 16'h9d17, 16'h9d18,
    16'h9d1c, 16'h9d1f, 16'h9d20, 16'h9d21, 16'h9d3c, 16'h9d3d,
    16'h9d3e, 16'h9d45, 16'h9d46, 16'h9d47};
  localparam logic [15:0] A_MON_THERMISTOR = 16'h9d48;
  localparam int MON_IX_OUT_FREQ = 0;
  localparam int MON_IX_SET_FREQ = 3;
  localparam int MON_IX_IN_TERM = 10;
  localparam int MON_IX_OUT_TERM = 11;
  localparam int MON_TOTAL = 23;

  // Speed display setting, in 0.01 steps
  localparam int SPD_W = 20;
  localparam logic [SPD_W-1:0] SPD_MIN = 20'h00001;
  localparam logic [SPD_W-1:0] SPD_MAX = 20'hf4178;

  localparam logic [EXC_W-1:0] EXC_NONE = 8'h00;
  localparam logic [EXC_W-1:0] EXC_ADDR = 8'h02;
  localparam logic [EXC_W-1:0] EXC_VALUE = 8'h03;

  typedef enum logic [2:0] {
    MDR_MODE_EXT, MDR_MODE_PANEL, MDR_MODE_JOG, MDR_MODE_NET,
    MDR_MODE_PANEL_EXT
  } mdr_mode_t;

  typedef enum logic [1:0] {
    MDR_CLR_PARAM, MDR_CLR_ALL, MDR_CLR_PARAM_KC, MDR_CLR_ALL_KC
  } mdr_clr_t;

  typedef struct packed {
    logic fault_occurred;
    logic safety_monitor;
    logic fault_relay;
    logic frequency_detected;
    logic overload_flag;
    logic up_to_frequency;
    logic reverse;
    logic forward;
    logic running;
  } mdr_status_t;

  typedef struct packed {
    logic high_speed_select;
    logic middle_speed_select;
    logic low_speed_select;
    logic reverse_start;
    logic forward_start;
  } mdr_inputs_t;
endpackage
